// ### hw/acs_calibration_sequencer.v
// Calibration sequencer: mode decode, calibration runs, result correction.
// Assumes a converter front end pulsing conv_done_in with raw_result_in valid.
// Overview of operation
// RULE1: Mode field selects internal zero, system zero or system full-scale calibration.
// RULE2: Each result has offset subtracted, then is multiplied by full-scale coefficient.
// RULE3: Starting a calibration drives the data-out/ready pin high.
// RULE4: At completion store coefficient, set ready, pin low if selected, go idle.
// RULE5: Internal zero calibration connects a zero input to the converter.
// RULE6: Host applies the zero or full-scale voltage before a system calibration.
// RULE7: Host should run zero-scale calibration before full-scale calibration.
// RULE8: Host sees end of calibration via ready flag or falling ready pin.
// RULE9: Offset calibrations last two conversion cycles.
// RULE10: System full-scale calibration lasts two cycles, then stores gain coefficient.
// RULE11: Idle, conversion and each calibration have distinct mode codes.
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
`include "acs_defines.vh"

module acs_calibration_sequencer (
  input wire clk_in,
  input wire sys_rst_in,
  input wire [`ACS_ADDR_W-1:0] addr_in,
  input wire [`ACS_DATA_W-1:0] wr_data_in,
  input wire wr_en_in,
  input wire rd_en_in,
  input wire conv_done_in,
  input wire [`ACS_RES_W-1:0] raw_result_in,
  input wire cs_n_in,
  output reg [`ACS_DATA_W-1:0] rd_data_out,
  output reg zero_input_sel_out,
  output reg conv_run_out,
  output reg dout_rdy_out,
  output reg irq_out
);

  localparam ST_IDLE = 2'h0;
  localparam ST_CONV = 2'h1;
  localparam ST_CAL = 2'h2;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [2:0] mode_reg;
  reg [1:0] cal_cnt_reg;
  reg nrdy_reg;
  reg cs_n_meta_reg;
  reg cs_n_sync_reg;
  reg [`ACS_RES_W-1:0] data_reg;
  reg [`ACS_RES_W-1:0] offset_reg;
  reg [`ACS_RES_W-1:0] fscale_reg;
  reg [1:0] irq_stat_reg;
  reg [1:0] irq_mask_reg;

  // Saturating correction: (raw - offset) * fs / one + mid
  function [`ACS_RES_W-1:0] acs_correct;
    input [`ACS_RES_W-1:0] raw;
    input [`ACS_RES_W-1:0] off;
    input [`ACS_RES_W-1:0] fs;
    reg signed [`ACS_RES_W+1:0] diff;
    reg signed [2*`ACS_RES_W+2:0] prod;
    reg signed [2*`ACS_RES_W+2:0] scaled;
    begin
      diff = $signed({2'b00, raw}) - $signed({2'b00, off});
      prod = diff * $signed({1'b0, fs});
      scaled = (prod >>> `ACS_FS_SHIFT) + $signed({24'h00_0000, `ACS_OFFSET_RST});
      if (scaled < 0) begin
        acs_correct = {`ACS_RES_W{1'b0}};
      end else if (scaled > $signed({24'h00_0000, {`ACS_RES_W{1'b1}}})) begin
        acs_correct = {`ACS_RES_W{1'b1}};
      end else begin
        acs_correct = scaled[`ACS_RES_W-1:0];
      end
    end
  endfunction

  // Gain from a full-scale reading; zero span falls back to unity
  function [`ACS_RES_W-1:0] acs_gain;
    input [`ACS_RES_W-1:0] raw;
    input [`ACS_RES_W-1:0] off;
    reg [`ACS_RES_W:0] span;
    reg [2*`ACS_RES_W:0] num;
    reg [2*`ACS_RES_W:0] quo;
    begin
      span = (raw > off) ? ({1'b0, raw} - {1'b0, off}) : {(`ACS_RES_W+1){1'b0}};
      num = {{(`ACS_RES_W+1){1'b0}}, `ACS_OFFSET_RST} << `ACS_FS_SHIFT;
      if (span == {(`ACS_RES_W+1){1'b0}}) begin
        acs_gain = `ACS_FS_ONE;
      end else begin
        quo = num / {{`ACS_RES_W{1'b0}}, span};
        acs_gain = (quo > {{(`ACS_RES_W+1){1'b0}}, {`ACS_RES_W{1'b1}}}) ?
          {`ACS_RES_W{1'b1}} : quo[`ACS_RES_W-1:0];
      end
    end
  endfunction

  wire wr_mode = wr_en_in && (addr_in == `ACS_OFF_MODE);
  wire [2:0] wr_md = wr_data_in[`ACS_MD_MSB:`ACS_MD_LSB];
  wire rd_status = rd_en_in && (addr_in == `ACS_OFF_STATUS);
  wire rd_data = rd_en_in && (addr_in == `ACS_OFF_DATA);
  wire rd_irq = rd_en_in && (addr_in == `ACS_OFF_IRQ_STAT);
  // RULE11: distinct calibration codes
  wire wr_is_cal = (wr_md == `ACS_MD_INT_ZERO) || (wr_md == `ACS_MD_SYS_ZERO) ||
    (wr_md == `ACS_MD_SYS_FULL);
  wire cal_last = (state_reg == ST_CAL) && conv_done_in &&
    (cal_cnt_reg == `ACS_CAL_CONV_CYCLES - 2'h1);
  wire conv_evt = (state_reg == ST_CONV) && conv_done_in;

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (wr_mode && wr_md == `ACS_MD_CONT) begin
          state_next = ST_CONV;
        end
      end
      ST_CONV: begin
        if (wr_mode && wr_md != `ACS_MD_CONT) begin
          state_next = ST_IDLE;
        end
      end
      ST_CAL: begin
        // RULE4: back to idle after calibration
        if (cal_last) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // RULE1: calibration start from mode write
    if (wr_mode && wr_is_cal) begin
      state_next = ST_CAL;
    end
  end

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_reg <= ST_IDLE;
      mode_reg <= `ACS_MD_IDLE;
      cal_cnt_reg <= 2'h0;
      nrdy_reg <= 1'b1;
      cs_n_meta_reg <= 1'b1;
      cs_n_sync_reg <= 1'b1;
      data_reg <= {`ACS_RES_W{1'b0}};
      offset_reg <= `ACS_OFFSET_RST;
      fscale_reg <= `ACS_FSCALE_RST;
      irq_stat_reg <= 2'h0;
      irq_mask_reg <= 2'h0;
      rd_data_out <= {`ACS_DATA_W{1'b0}};
      zero_input_sel_out <= 1'b0;
      conv_run_out <= 1'b0;
      dout_rdy_out <= 1'b1;
      irq_out <= 1'b0;
    end else begin
      cs_n_meta_reg <= cs_n_in;
      cs_n_sync_reg <= cs_n_meta_reg;
      state_reg <= state_next;
      if (wr_mode) begin
        mode_reg <= wr_md;
      end else if (cal_last) begin
        mode_reg <= `ACS_MD_IDLE;
      end
      if (wr_en_in && addr_in == `ACS_OFF_OFFSET) begin
        offset_reg <= wr_data_in[`ACS_RES_W-1:0];
      end
      if (wr_en_in && addr_in == `ACS_OFF_FSCALE) begin
        fscale_reg <= wr_data_in[`ACS_RES_W-1:0];
      end
      if (wr_en_in && addr_in == `ACS_OFF_IRQ_MASK) begin
        irq_mask_reg <= wr_data_in[1:0];
      end
      // RULE9: two-cycle calibration count
      if (wr_mode && wr_is_cal) begin
        cal_cnt_reg <= 2'h0;
      end else if (state_reg == ST_CAL && conv_done_in) begin
        cal_cnt_reg <= cal_cnt_reg + 2'h1;
      end
      // RULE4: store coefficient at completion
      if (cal_last && mode_reg != `ACS_MD_SYS_FULL) begin
        offset_reg <= raw_result_in;
      end
      // RULE10: gain stored after full-scale run
      if (cal_last && mode_reg == `ACS_MD_SYS_FULL) begin
        fscale_reg <= acs_gain(raw_result_in, offset_reg);
      end
      // RULE2: offset then gain correction
      if (conv_evt) begin
        data_reg <= acs_correct(raw_result_in, offset_reg, fscale_reg);
      end
      // RULE3: not ready while calibration runs
      if (wr_mode && wr_is_cal) begin
        nrdy_reg <= 1'b1;
      end else if (cal_last || conv_evt) begin
        nrdy_reg <= 1'b0;
      end else if (rd_data) begin
        nrdy_reg <= 1'b1;
      end
      // Set wins over the read clear
      irq_stat_reg <= (rd_irq ? 2'h0 : irq_stat_reg) |
        {cal_last, conv_evt};
      irq_out <= |(irq_stat_reg & irq_mask_reg);
      // RULE5: zero input during internal zero run
      zero_input_sel_out <= (state_next == ST_CAL) &&
        ((wr_mode && wr_is_cal) ? (wr_md == `ACS_MD_INT_ZERO) :
        (mode_reg == `ACS_MD_INT_ZERO));
      conv_run_out <= (state_next != ST_IDLE);
      // RULE4: pin low only with chip select low
      if (wr_mode && wr_is_cal) begin
        dout_rdy_out <= 1'b1;
      end else begin
        dout_rdy_out <= cs_n_sync_reg | nrdy_reg;
      end
      rd_data_out <= {`ACS_DATA_W{1'b0}};
      if (rd_en_in) begin
        case (addr_in)
          `ACS_OFF_MODE: rd_data_out <= {29'h0000_0000, mode_reg};
          `ACS_OFF_STATUS: rd_data_out <= {24'h00_0000, nrdy_reg, 7'h00};
          `ACS_OFF_DATA: rd_data_out <= {8'h00, data_reg};
          `ACS_OFF_OFFSET: rd_data_out <= {8'h00, offset_reg};
          `ACS_OFF_FSCALE: rd_data_out <= {8'h00, fscale_reg};
          `ACS_OFF_IRQ_STAT: rd_data_out <= {30'h0000_0000, irq_stat_reg};
          `ACS_OFF_IRQ_MASK: rd_data_out <= {30'h0000_0000, irq_mask_reg};
          default: rd_data_out <= {`ACS_DATA_W{1'b0}};
        endcase
      end
    end
  end

endmodule

// ### hw/acs_defines.vh
// Constants for the calibration sequencer: bus offsets, fields, modes, widths.
// Assumes a 100 MHz system clock and a one-cycle conversion-done pulse.
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH

`define ACS_ADDR_W 4
`define ACS_DATA_W 32
`define ACS_RES_W 24
`define ACS_OFF_MODE 4'h0
`define ACS_OFF_STATUS 4'h1
`define ACS_OFF_DATA 4'h2
`define ACS_OFF_OFFSET 4'h3
`define ACS_OFF_FSCALE 4'h4
`define ACS_OFF_IRQ_STAT 4'h5
`define ACS_OFF_IRQ_MASK 4'h6
`define ACS_MD_LSB 0
`define ACS_MD_MSB 2
`define ACS_MD_CONT 3'h0
`define ACS_MD_IDLE 3'h2
`define ACS_MD_INT_ZERO 3'h4
`define ACS_MD_SYS_ZERO 3'h6
`define ACS_MD_SYS_FULL 3'h7
`define ACS_ST_NRDY_BIT 7
`define ACS_CAL_CONV_CYCLES 2'h2
`define ACS_OFFSET_RST 24'h80_0000
`define ACS_FSCALE_RST 24'h55_5555
`define ACS_FS_ONE 24'h40_0000
`define ACS_FS_SHIFT 22
`define ACS_IRQ_CONV 0
`define ACS_IRQ_CAL 1

`endif

// ### test/acs_front_model.sv
// Converter front end model: one done pulse per 8 cycles of run.
// Assumes run and zero select come straight from the sequencer.
`timescale 1ns/100ps
module acs_front_model (
  input wire clk_in,
  input wire run_in,
  input wire zero_sel_in,
  input wire [23:0] level_in,
  output reg done_out = 1'b0,
  output reg [23:0] raw_out = 24'h00_0000
);
  reg [2:0] cnt_reg = 3'h0;
  wire hit = run_in && cnt_reg == 3'h7;
  always @(posedge clk_in) begin
    cnt_reg <= run_in ? cnt_reg + 3'h1 : 3'h0;
    done_out <= hit;
    raw_out <= hit ? (zero_sel_in ? 24'h00_0000 : level_in) : ~raw_out;
  end
endmodule

// ### test/acs_cal_props.sv
// Port checker for the calibration sequencer.
// Assumes done pulses come only while the sequencer runs.
`timescale 1ns/100ps
`include "acs_defines.vh"
module acs_cal_props (
  input wire clk_in,
  input wire sys_rst_in,
  input wire [3:0] addr_in,
  input wire [31:0] wr_data_in,
  input wire wr_en_in,
  input wire conv_done_in,
  input wire cs_n_in,
  input wire zero_input_sel_out,
  input wire conv_run_out,
  input wire dout_rdy_out
);
  reg act_reg = 1'b0;
  reg [1:0] cnt_reg = 2'h0;
  wire md_wr = wr_en_in && addr_in == `ACS_OFF_MODE;
  wire cal_wr = md_wr && wr_data_in[2] && wr_data_in[1:0] != 2'h1;
  always @(posedge clk_in) begin
    cnt_reg <= (sys_rst_in || cal_wr) ? 2'h0 : cnt_reg + {1'b0, conv_done_in};
    act_reg <= !sys_rst_in && (cal_wr || act_reg && !(conv_done_in && cnt_reg == 2'h1));
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_cal_wr;
    cal_wr;
  endsequence
  sequence s_last;
    act_reg && conv_done_in && cnt_reg == 2'h1;
  endsequence
  a_cal_busy: assert property (s_cal_wr |=> conv_run_out && dout_rdy_out)
    else $error("no busy at start");
  a_rdy_held: assert property (act_reg |-> dout_rdy_out)
    else $error("ready during cal");
  a_cal_holds: assert property (act_reg |-> conv_run_out)
    else $error("cal ended early");
  a_cal_ends: assert property (s_last |-> ##[1:2] !conv_run_out)
    else $error("cal overran");
  a_zero_conn: assert property (s_cal_wr ##0 !wr_data_in[1] |=> zero_input_sel_out)
    else $error("zero not connected");
  a_sys_open: assert property (s_cal_wr ##0 wr_data_in[1] |=> !zero_input_sel_out)
    else $error("zero on system cal");
  a_zero_drop: assert property (s_last |-> ##[1:2] !zero_input_sel_out)
    else $error("zero kept");
  a_cs_high: assert property (cs_n_in [*4] |=> dout_rdy_out)
    else $error("pin low unselected");
endmodule
bind acs_calibration_sequencer acs_cal_props i_props (.clk_in(clk_in),
  .sys_rst_in(sys_rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in),
  .conv_done_in(conv_done_in), .cs_n_in(cs_n_in), .zero_input_sel_out(zero_input_sel_out),
  .conv_run_out(conv_run_out), .dout_rdy_out(dout_rdy_out));

// ### test/tb_top.sv
// Bench: register tasks, front-end model, calibration runs.
// Assumes the port checker is bound to the sequencer.
`timescale 1ns/100ps
`include "acs_defines.vh"
module tb_top;
  reg clk, rst = 1, we = 0, re = 0, cs_n = 0;
  reg [3:0] adr = 0;
  reg [31:0] wd = 0, rv, fs;
  reg [23:0] lvl = 0;
  wire [31:0] rd;
  wire zs, run, rdy, irq, dn;
  wire [23:0] raw;
  integer mismatches = 0, checked = 0;
  acs_calibration_sequencer i_dut (.clk_in(clk), .sys_rst_in(rst), .addr_in(adr),
    .wr_data_in(wd), .wr_en_in(we), .rd_en_in(re), .conv_done_in(dn),
    .raw_result_in(raw), .cs_n_in(cs_n), .rd_data_out(rd), .zero_input_sel_out(zs),
    .conv_run_out(run), .dout_rdy_out(rdy), .irq_out(irq));
  acs_front_model i_fe (.clk_in(clk), .run_in(run), .zero_sel_in(zs), .level_in(lvl),
    .done_out(dn), .raw_out(raw));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    we <= 1;
    @(posedge clk);
    we <= 0;
  endtask
  task rdr(input [3:0] a);
    @(posedge clk);
    adr <= a;
    re <= 1;
    @(posedge clk);
    re <= 0;
    #1 rv = rd;
  endtask
  task t_cal(input [2:0] md, input [23:0] l, input [3:0] ra, input [31:0] x, im);
    integer i;
    lvl = l;
    wr(`ACS_OFF_IRQ_MASK, im);
    wr(`ACS_OFF_MODE, md);
    #1 chk("pin", rdy, 1);
    rv = 32'h80;
    for (i = 0; i < 40 && rv[7] !== 1'b0; i = i + 1) rdr(`ACS_OFF_STATUS);
    chk("nrdy", rv[7], 0);
    chk("pin", rdy, 0);
    rdr(ra);
    chk("coef", rv, x);
    rdr(`ACS_OFF_MODE);
    chk("mode", rv, `ACS_MD_IDLE);
    chk("irq", irq, im[1]);
    rdr(`ACS_OFF_IRQ_STAT);
    chk("cal", rv[1], 1);
    repeat (2) @(posedge clk);
    #1 chk("irq", irq, 0);
  endtask
  task complete_run;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches = mismatches + 1;
    complete_run;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    rdr(`ACS_OFF_FSCALE);
    chk("fs", rv, `ACS_FSCALE_RST);
    rdr(4'hf);
    chk("map", rv, 0);
    t_cal(`ACS_MD_INT_ZERO, 24'h12_3456, `ACS_OFF_OFFSET, 0, 0);
    t_cal(`ACS_MD_SYS_ZERO, 24'h10_0000, `ACS_OFF_OFFSET, 32'h10_0000, 2);
    fs = (64'h1 << 45) / 64'h70_0000;
    t_cal(`ACS_MD_SYS_FULL, 24'h80_0000, `ACS_OFF_FSCALE, fs, 2);
    lvl = 24'h10_1234;
    wr(`ACS_OFF_MODE, `ACS_MD_CONT);
    repeat (12) @(posedge clk);
    rdr(`ACS_OFF_DATA);
    chk("data", rv, ((64'h1234 * fs) >> `ACS_FS_SHIFT) + 32'h80_0000);
    rdr(`ACS_OFF_IRQ_STAT);
    chk("conv irq", rv[0], 1);
    @(posedge clk);
    cs_n <= 1;
    repeat (5) @(posedge clk);
    #1 chk("pin", rdy, 1);
    complete_run;
  end
endmodule
